/* rtl/lpcb_pkg.sv */
package lpcb_pkg;
  // Device configuration port
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] ADDR_DEVICE_IDENT = 12'h450;
  localparam logic [11:0] ADDR_BANK_IDENT = 12'h451;
  localparam logic [11:0] ADDR_LANE0_IDENT = 12'h452;
  localparam logic [11:0] ADDR_DESCR_LANES = 12'h453;
  localparam logic [11:0] ADDR_OCTETS = 12'h454;
  localparam logic [11:0] ADDR_FRAMES_MF = 12'h455;
  localparam logic [11:0] ADDR_CONVERTERS = 12'h456;
  localparam logic [11:0] ADDR_CS_RES = 12'h457;
  // Field positions
  localparam int POS_ADJDIR = 6;
  localparam int POS_PHADJ = 5;
  localparam int POS_DESCR_EN = 7;
  localparam int POS_CS = 6;
  // Reset values
  localparam logic [7:0] RST_DEVICE_IDENT = 8'h00;
  localparam logic [7:0] RST_BANK_IDENT = 8'h00;
  localparam logic RST_ADJDIR = 1'b0;
  localparam logic RST_PHADJ = 1'b0;
  localparam logic [4:0] RST_LANE0_ID = 5'h00;
  localparam logic RST_DESCR_EN = 1'b1;
  localparam logic [4:0] RST_LANE_COUNT = 5'h07;
  localparam logic [7:0] RST_OCTETS = 8'h00;
  localparam logic [4:0] RST_FRAMES_MF = 5'h1f;
  localparam logic [7:0] RST_CONVERTERS = 8'h01;
  localparam logic [1:0] RST_CS = 2'h0;
  // Frame-count encodings
  localparam logic [4:0] FRAMES_MF_16 = 5'h0f;
  localparam logic [4:0] FRAMES_MF_32 = 5'h1f;
  // Controller APB registers (byte addresses)
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_CMD = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam int CMD_POS_WDATA = 0;
  localparam int CMD_POS_ADDR = 8;
  localparam int CMD_POS_WRITE = 24;
  localparam int CTRL_POS_SRST = 0;
  localparam int STAT_POS_BUSY = 0;
  localparam int STAT_POS_REFUSED = 1;
  localparam int STAT_POS_RDATA = 8;
  localparam logic RST_SOFT_RESET = 1'b1;
  typedef enum logic [1:0] {
    LPCB_IDLE = 2'b00,
    LPCB_REQ = 2'b01,
    LPCB_WAIT = 2'b10
  } lpcb_state_t;
endpackage

/* rtl/lpcb_if.sv */
`timescale 1ns/10ps
interface lpcb_if;
  logic cfg_req;
  logic cfg_write;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_ack;
  logic [7:0] cfg_rdata;
  logic soft_reset;
  modport dev (
    input cfg_req, cfg_write, cfg_addr, cfg_wdata, soft_reset,
    output cfg_ack, cfg_rdata
  );
  modport host (
    output cfg_req, cfg_write, cfg_addr, cfg_wdata, soft_reset,
    input cfg_ack, cfg_rdata
  );
endinterface

/* rtl/lpcb_dev.sv */
`timescale 1ns/10ps
// Function
// - Host writes fields only during soft reset
// - Device ident must match lane 0 value
// - Bank ident, 8-bit RW, resets zero
// - Bit 6: LMFC adjust direction, subclass 2
// - Bit 5: phase adjust request, subclass 2
// - Bits 4:0: lane 0 id, RW, zero
// - Bit 7 descramble enable, resets one
// - Lane count minus one, RO, 0x7
// - Octets per frame RO, not used
// - Frames per multiframe minus one, use 32
// - Converter count minus one, RO, 0x1
// - Control bits per sample zero, RO
module lpcb_dev (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration port
  lpcb_if.dev cfg,
  // Link parameters to the deframer
  output logic [7:0] device_ident,
  output logic [7:0] bank_ident,
  output logic adjust_dir,
  output logic phase_adjust,
  output logic [4:0] lane0_id,
  output logic descramble_en,
  output logic [4:0] lane_count,
  output logic [7:0] octets_per_frame,
  output logic [4:0] frames_per_mf,
  output logic [7:0] converter_count,
  output logic [1:0] control_bits,
  output logic deframer_in_reset
);
  logic wr;
  logic [7:0] next_rdata;

  assign wr = cfg.cfg_req & cfg.cfg_write;

  // The far end keeps writes inside soft reset; the bank stores what it gets
  always_ff @(posedge mclk) begin
    if (srst) begin
      device_ident <= lpcb_pkg::RST_DEVICE_IDENT;
    end else if (wr && cfg.cfg_addr == lpcb_pkg::ADDR_DEVICE_IDENT) begin
      device_ident <= cfg.cfg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bank_ident <= lpcb_pkg::RST_BANK_IDENT;
    end else if (wr && cfg.cfg_addr == lpcb_pkg::ADDR_BANK_IDENT) begin
      bank_ident <= cfg.cfg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      adjust_dir <= lpcb_pkg::RST_ADJDIR;
      phase_adjust <= lpcb_pkg::RST_PHADJ;
      lane0_id <= lpcb_pkg::RST_LANE0_ID;
    end else if (wr && cfg.cfg_addr == lpcb_pkg::ADDR_LANE0_IDENT) begin
      adjust_dir <= cfg.cfg_wdata[lpcb_pkg::POS_ADJDIR];
      phase_adjust <= cfg.cfg_wdata[lpcb_pkg::POS_PHADJ];
      lane0_id <= cfg.cfg_wdata[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      descramble_en <= lpcb_pkg::RST_DESCR_EN;
    end else if (wr && cfg.cfg_addr == lpcb_pkg::ADDR_DESCR_LANES) begin
      descramble_en <= cfg.cfg_wdata[lpcb_pkg::POS_DESCR_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      frames_per_mf <= lpcb_pkg::RST_FRAMES_MF;
    end else if (wr && cfg.cfg_addr == lpcb_pkg::ADDR_FRAMES_MF) begin
      frames_per_mf <= cfg.cfg_wdata[4:0];
    end
  end

  // Read-only fields hold their reset value; writes to them are dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      lane_count <= lpcb_pkg::RST_LANE_COUNT;
      octets_per_frame <= lpcb_pkg::RST_OCTETS;
      converter_count <= lpcb_pkg::RST_CONVERTERS;
      control_bits <= lpcb_pkg::RST_CS;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      deframer_in_reset <= lpcb_pkg::RST_SOFT_RESET;
    end else begin
      deframer_in_reset <= cfg.soft_reset;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (cfg.cfg_addr)
      lpcb_pkg::ADDR_DEVICE_IDENT: next_rdata = device_ident;
      lpcb_pkg::ADDR_BANK_IDENT: next_rdata = bank_ident;
      lpcb_pkg::ADDR_LANE0_IDENT: next_rdata = {1'b0, adjust_dir, phase_adjust, lane0_id};
      lpcb_pkg::ADDR_DESCR_LANES: next_rdata = {descramble_en, 2'b00, lane_count};
      lpcb_pkg::ADDR_OCTETS: next_rdata = octets_per_frame;
      lpcb_pkg::ADDR_FRAMES_MF: next_rdata = {3'b000, frames_per_mf};
      lpcb_pkg::ADDR_CONVERTERS: next_rdata = converter_count;
      lpcb_pkg::ADDR_CS_RES: next_rdata = {control_bits, 6'h00};
      default: next_rdata = 8'h00;
    endcase
  end

  // One-cycle answer to every request
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg.cfg_ack <= 1'b0;
      cfg.cfg_rdata <= 8'h00;
    end else begin
      cfg.cfg_ack <= cfg.cfg_req;
      if (cfg.cfg_req && !cfg.cfg_write) begin
        cfg.cfg_rdata <= next_rdata;
      end
    end
  end
endmodule

/* rtl/lpcb_host.sv */
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module lpcb_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Device configuration port
  lpcb_if.host cfg
);
  lpcb_pkg::lpcb_state_t state;
  logic access;
  logic cmd_wr;
  logic busy;
  logic refused;
  logic [7:0] last_rdata;
  logic writable;
  logic refuse_now;
  logic [11:0] cmd_addr;
  logic [7:0] cmd_data;
  logic mapped;

  assign access = psel & penable & ~pready;
  assign cmd_wr = access & pwrite & (paddr == lpcb_pkg::APB_CMD);
  assign busy = (state != lpcb_pkg::LPCB_IDLE);
  assign cmd_addr = pwdata[lpcb_pkg::CMD_POS_ADDR +: 12];
  assign cmd_data = pwdata[lpcb_pkg::CMD_POS_WDATA +: 8];
  assign mapped = (paddr == lpcb_pkg::APB_CTRL) || (paddr == lpcb_pkg::APB_CMD) ||
                  (paddr == lpcb_pkg::APB_STATUS);
  assign writable = (cmd_addr == lpcb_pkg::ADDR_DEVICE_IDENT) ||
                    (cmd_addr == lpcb_pkg::ADDR_BANK_IDENT) ||
                    (cmd_addr == lpcb_pkg::ADDR_LANE0_IDENT) ||
                    (cmd_addr == lpcb_pkg::ADDR_DESCR_LANES) ||
                    (cmd_addr == lpcb_pkg::ADDR_FRAMES_MF);
  // Parameter writes outside soft reset, or a non-32 frame count, never reach the device
  assign refuse_now = pwdata[lpcb_pkg::CMD_POS_WRITE] & writable &
                      (~cfg.soft_reset |
                       ((cmd_addr == lpcb_pkg::ADDR_FRAMES_MF) &&
                        (cmd_data[4:0] != lpcb_pkg::FRAMES_MF_32)));

  // One wait state on every APB access
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      prdata <= 32'h0000_0000;
      if (access && !pwrite && paddr == lpcb_pkg::APB_CTRL) begin
        prdata <= {31'h0000_0000, cfg.soft_reset};
      end else if (access && !pwrite && paddr == lpcb_pkg::APB_STATUS) begin
        prdata <= {16'h0000, last_rdata, 6'h00, refused, busy};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg.soft_reset <= lpcb_pkg::RST_SOFT_RESET;
    end else if (access && pwrite && paddr == lpcb_pkg::APB_CTRL) begin
      cfg.soft_reset <= pwdata[lpcb_pkg::CTRL_POS_SRST];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      refused <= 1'b0;
    end else if (cmd_wr && !busy) begin
      refused <= refuse_now;
    end else if (cmd_wr) begin
      refused <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= lpcb_pkg::LPCB_IDLE;
      cfg.cfg_req <= 1'b0;
      cfg.cfg_write <= 1'b0;
      cfg.cfg_addr <= 12'h000;
      cfg.cfg_wdata <= 8'h00;
    end else begin
      case (state)
        lpcb_pkg::LPCB_IDLE: begin
          if (cmd_wr && !refuse_now) begin
            state <= lpcb_pkg::LPCB_REQ;
            cfg.cfg_req <= 1'b1;
            cfg.cfg_write <= pwdata[lpcb_pkg::CMD_POS_WRITE];
            cfg.cfg_addr <= cmd_addr;
            cfg.cfg_wdata <= cmd_data;
          end
        end
        lpcb_pkg::LPCB_REQ: begin
          cfg.cfg_req <= 1'b0;
          state <= lpcb_pkg::LPCB_WAIT;
        end
        lpcb_pkg::LPCB_WAIT: begin
          if (cfg.cfg_ack) begin
            state <= lpcb_pkg::LPCB_IDLE;
          end
        end
        default: begin
          state <= lpcb_pkg::LPCB_IDLE;
          cfg.cfg_req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      last_rdata <= 8'h00;
    end else if (state == lpcb_pkg::LPCB_WAIT && cfg.cfg_ack && !cfg.cfg_write) begin
      last_rdata <= cfg.cfg_rdata;
    end
  end
endmodule

/* dv/lpcb_monitor.sv */
`timescale 1ns/10ps
module lpcb_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration port
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [7:0] cfg_rdata,
  input wire logic soft_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic rd;
  logic wr;
  assign rd = cfg_req && !cfg_write;
  assign wr = cfg_req && cfg_write;
  chk_ack_one_later: assert property (cfg_req |=> cfg_ack ##1 !cfg_ack)
    else $error("ack not one cycle after request");
  chk_ack_has_cause: assert property ($rose(cfg_ack) |-> $past(cfg_req))
    else $error("ack without request");
  chk_write_in_reset: assert property (
    wr && (cfg_addr inside {[12'h450:12'h453], 12'h455}) |-> soft_reset)
    else $error("link field written outside soft reset");
  chk_frames_code: assert property (wr && cfg_addr == 12'h455 |-> cfg_wdata[4:0] == 5'h1f)
    else $error("frame count other than 32 written");
  chk_lane_count: assert property (rd && cfg_addr == 12'h453 |=> cfg_rdata[6:0] == 7'h07)
    else $error("lane count read wrong");
  chk_octets_ro: assert property (rd && cfg_addr == 12'h454 |=> cfg_rdata == 8'h00)
    else $error("octets field read wrong");
  chk_conv_count: assert property (rd && cfg_addr == 12'h456 |=> cfg_rdata == 8'h01)
    else $error("converter count read wrong");
  chk_ctrl_bits: assert property (rd && cfg_addr == 12'h457 |=> cfg_rdata == 8'h00)
    else $error("control bits read nonzero");
  chk_lane0_rsvd: assert property (rd && cfg_addr == 12'h452 |=> !cfg_rdata[7])
    else $error("reserved bit read nonzero");
endmodule

/* dv/link_param_config_bank_tb.sv */
`timescale 1ns/10ps
module link_param_config_bank_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic descr_en;
  logic dfr_rst;
  logic [7:0] dev_id;
  logic [7:0] bank_id;
  logic adj;
  logic phadj;
  logic [4:0] lid;
  logic [4:0] lcnt;
  logic [7:0] opf;
  logic [4:0] fpm;
  logic [7:0] conv;
  logic [1:0] cbits;
  logic [31:0] rv;
  logic er;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h1f, 8'h01, 8'h00};
  logic [7:0] wr_val [8] = '{8'ha5, 8'h5a, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] wr_exp [8] = '{8'ha5, 8'h5a, 8'h7f, 8'h07, 8'h00, 8'h1f, 8'h01, 8'h00};
  always #20 mclk = ~mclk;
  lpcb_if lpcb_if_inst ();
  lpcb_host lpcb_host_inst (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cfg(lpcb_if_inst.host));
  lpcb_dev lpcb_dev_inst (.mclk(mclk), .srst(srst), .cfg(lpcb_if_inst.dev),
    .device_ident(dev_id), .bank_ident(bank_id), .adjust_dir(adj), .phase_adjust(phadj),
    .lane0_id(lid), .descramble_en(descr_en), .lane_count(lcnt), .octets_per_frame(opf),
    .frames_per_mf(fpm), .converter_count(conv), .control_bits(cbits),
    .deframer_in_reset(dfr_rst));
  lpcb_monitor lpcb_monitor_inst (.mclk(mclk), .srst(srst),
    .cfg_req(lpcb_if_inst.cfg_req), .cfg_write(lpcb_if_inst.cfg_write),
    .cfg_addr(lpcb_if_inst.cfg_addr), .cfg_wdata(lpcb_if_inst.cfg_wdata),
    .cfg_ack(lpcb_if_inst.cfg_ack), .cfg_rdata(lpcb_if_inst.cfg_rdata),
    .soft_reset(lpcb_if_inst.soft_reset));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; result left in rv and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask
  // Device access through CMD, then poll STATUS until idle
  task automatic cfg_op(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    apb(1'b1, lpcb_pkg::APB_CMD, {7'h0, w, 4'h0, a, d});
    i = 0;
    do begin
      apb(1'b0, lpcb_pkg::APB_STATUS, 32'h0);
      i++;
    end while (rv[0] !== 1'b0 && i < 10);
    if (rv[0] !== 1'b0) begin
      err_count++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    chk(dfr_rst, 1'b1);
    apb(1'b0, lpcb_pkg::APB_CTRL, 32'h0);
    chk(rv[0], 1'b1);
    for (int k = 0; k < 8; k++) begin
      cfg_op(1'b0, 12'h450 + 12'(k), 8'h00);
      chk(rv[15:8], rst_val[k]);
    end
    for (int k = 0; k < 8; k++) begin
      cfg_op(1'b1, 12'h450 + 12'(k), wr_val[k]);
      chk(rv[1], 1'b0);
      cfg_op(1'b0, 12'h450 + 12'(k), 8'h00);
      chk(rv[15:8], wr_exp[k]);
    end
    chk(descr_en, 1'b0);
    chk(dev_id, 8'ha5);
    chk(bank_id, 8'h5a);
    chk({adj, phadj, lid}, 7'h7f);
    chk(fpm, 5'h1f);
    chk({lcnt, opf, conv, cbits}, {5'h07, 8'h00, 8'h01, 2'h0});
    cfg_op(1'b1, 12'h455, 8'h0f);
    chk(rv[1], 1'b1);
    cfg_op(1'b0, 12'h455, 8'h00);
    chk(rv[15:8], 8'h1f);
    apb(1'b1, lpcb_pkg::APB_CTRL, 32'h0);
    cfg_op(1'b1, 12'h450, 8'h11);
    chk(rv[1], 1'b1);
    chk(dfr_rst, 1'b0);
    cfg_op(1'b0, 12'h450, 8'h00);
    chk(rv[15:8], 8'ha5);
    chk(dev_id, 8'ha5);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1);
    chk(rv, 32'h0);
    print_verdict();
  end
endmodule
